/* rtl/pad_mux_cell.sv */
// One pad cell: output multiplexers and sampled input
`timescale 1ns/1ps
`default_nettype none
module pad_mux_cell #(
    parameter bit IMPL = 1'b1,
    parameter bit SHARED = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic dir_i,
    input wire logic lat_i,
    input wire logic own_i,
    input wire logic p_data_i,
    input wire logic p_oe_n_i,
    input wire logic pad_i,
    input wire logic analog_i,
    output logic pad_o,
    output logic pad_oe_n_o,
    output logic pin_o
);
    // ---------------------------------------------------------------
    // Output multiplexers
    // ---------------------------------------------------------------
    wire logic take; // Peripheral currently owns the pad
    logic sample_reg; // Sampled pad level

    // An input-only partner never competes, so no mux is built
    assign take = SHARED & own_i;
    // Peripheral wins both data and enable while it owns the pad
    assign pad_o = IMPL & (take ? p_data_i : lat_i);
    // Port drive follows direction bit: 1 means driver off
    assign pad_oe_n_o = ~IMPL | (take ? p_oe_n_i : dir_i);

    // ---------------------------------------------------------------
    // Input path
    // ---------------------------------------------------------------
    // One stage; a read right after a change may see the old level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_reg <= 1'b0;
        end else if (ce_i) begin
            sample_reg <= pad_i & IMPL;
        end
    end

    // Analog channels read low whatever the pad does
    assign pin_o = sample_reg & ~analog_i;
endmodule
`default_nettype wire

/* rtl/parallel_io_port_bank.sv */
// Parallel port bank B..F with Wishbone register access
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_port_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [13:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire pio_pkg::periph_t periph_i,
    input wire pio_pkg::pin_vec_t pad_in_i,
    output pio_pkg::pad_drv_t pad_o,
    output pio_pkg::pin_vec_t periph_in_o,
    output logic [pio_pkg::AN_W-1:0] adc_en_o
);
    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    wire logic req; // Master has a cycle open
    wire logic do_wr; // Write commits at the acked edge
    wire logic latch_rd; // Read data captured on the ask edge
    logic ack_reg; // One-cycle answer
    logic [31:0] dat_reg; // Registered read data

    assign req = cyc_i & stb_i;
    assign do_wr = req & we_i & ack_reg;
    assign latch_rd = req & ~ack_reg;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Answer one cycle after the request, drop it the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= latch_rd;
        end
    end

    // ---------------------------------------------------------------
    // Analog configuration
    // ---------------------------------------------------------------
    wire logic hit_an; // Address selects analog config
    wire logic [pio_pkg::AN_W-1:0] an_next;
    logic [pio_pkg::AN_W-1:0] an_reg; // One marks an analog channel
    pio_pkg::pin_vec_t analog_all; // Per pad analog flag

    assign hit_an = (adr_i == pio_pkg::ANALOG_IDX);
    assign an_next = {sel_i[1] ? dat_i[8] : an_reg[8],
        sel_i[0] ? dat_i[7:0] : an_reg[7:0]};
    assign analog_all = {{(pio_pkg::NPIN - pio_pkg::AN_W){1'b0}},
        an_reg};
    // Converter gets only pins marked analog
    assign adc_en_o = an_reg;

    // Analog config store, all digital out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            an_reg <= pio_pkg::ANALOG_RST;
        end else if (ce_i && do_wr && hit_an) begin
            an_reg <= an_next;
        end
    end

    // ---------------------------------------------------------------
    // Per-port storage and decode
    // ---------------------------------------------------------------
    pio_pkg::pin_vec_t dir_all; // All direction bits
    pio_pkg::pin_vec_t lat_all; // All latch bits
    pio_pkg::pin_vec_t pin_all; // All sampled pin levels
    pio_pkg::pin_vec_t impl_all; // Implemented pin mask
    pio_pkg::pin_vec_t shared_all; // Pins with an output partner
    logic [15:0] rd_chain [pio_pkg::NPORT+1]; // Read OR chain

    assign rd_chain[0] = hit_an ?
        {{(16 - pio_pkg::AN_W){1'b0}}, an_reg} : 16'h0000;

    genvar p;
    genvar b;
    generate
        for (p = 0; p < pio_pkg::NPORT; p++) begin : g_port
            wire logic hit_dir;
            wire logic hit_pin;
            wire logic hit_lat;
            wire logic [15:0] rd_word;

            // Pin register write lands in the latch too
            assign hit_dir = (adr_i == pio_pkg::DIR_IDX[p]);
            assign hit_pin = (adr_i == pio_pkg::PIN_IDX[p]);
            assign hit_lat = (adr_i == pio_pkg::LAT_IDX[p]);
            assign impl_all[p*16 +: 16] = pio_pkg::IMPL_MASK[p];
            assign shared_all[p*16 +: 16] = ~pio_pkg::DEDICATED[p];

            // Latch reads latch, pin reads the sampled pads
            assign rd_word =
                hit_dir ? dir_all[p*16 +: 16] :
                hit_lat ? lat_all[p*16 +: 16] :
                hit_pin ? pin_all[p*16 +: 16] :
                16'h0000;
            assign rd_chain[p+1] = rd_chain[p] | rd_word;

            port_regs #(
                .MASK(pio_pkg::IMPL_MASK[p])
            ) u_regs (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .wr_dir_i(do_wr & hit_dir),
                .wr_lat_i(do_wr & (hit_lat | hit_pin)),
                .sel_i(sel_i[1:0]),
                .wdata_i(dat_i[15:0]),
                .dir_o(dir_all[p*16 +: 16]),
                .lat_o(lat_all[p*16 +: 16])
            );

            // One cell per bit; missing bits are built disabled
            for (b = 0; b < 16; b++) begin : g_bit
                pad_mux_cell #(
                    .IMPL(pio_pkg::IMPL_MASK[p][b]),
                    .SHARED(~pio_pkg::DEDICATED[p][b])
                ) u_cell (
                    .clk_i(clk_i),
                    .rst_i(rst_i),
                    .ce_i(ce_i),
                    .dir_i(dir_all[p*16+b]),
                    .lat_i(lat_all[p*16+b]),
                    .own_i(periph_i.own[p*16+b]),
                    .p_data_i(periph_i.data[p*16+b]),
                    .p_oe_n_i(periph_i.oe_n[p*16+b]),
                    .pad_i(pad_in_i[p*16+b]),
                    .analog_i(analog_all[p*16+b]),
                    .pad_o(pad_o.data[p*16+b]),
                    .pad_oe_n_o(pad_o.oe_n[p*16+b]),
                    .pin_o(pin_all[p*16+b])
                );
            end
        end
    endgenerate

    // Pads always feed the peripherals as well as the port
    assign periph_in_o = pad_in_i & impl_all;

    // ---------------------------------------------------------------
    // Read data register
    // ---------------------------------------------------------------
    // Unmapped addresses still ack and return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (ce_i && latch_rd) begin
            dat_reg <= {16'h0000, rd_chain[pio_pkg::NPORT]};
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    pio_pkg::pin_vec_t port_own; // Pads really owned by peripherals
    assign port_own = periph_i.own & shared_all & impl_all;

    chk_reset_inputs: assert property (
        @(posedge clk_i) $past(rst_i) && !rst_i |-> dir_all == impl_all
    ) else $error("direction not all inputs after reset");

    chk_periph_wins: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((pad_o.data ^ periph_i.data) & port_own) == '0 &&
        ((pad_o.oe_n ^ periph_i.oe_n) & port_own) == '0
    ) else $error("peripheral lost pad ownership");

    chk_port_drives: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((pad_o.data ^ lat_all) & ~port_own & impl_all) == '0 &&
        ((pad_o.oe_n ^ dir_all) & ~port_own & impl_all) == '0
    ) else $error("port drive does not follow latch and direction");

    chk_missing_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((dir_all | lat_all | pin_all) & ~impl_all) == '0 &&
        (pad_o.oe_n & ~impl_all) == ~impl_all
    ) else $error("unimplemented bit active");

    chk_sample_stage: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> pin_all == ($past(pad_in_i) & impl_all & ~analog_all)
    ) else $error("pin state not one stage behind pad");

    chk_analog_low: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pin_all & analog_all) == '0
    ) else $error("analog channel reads high");

    chk_pin_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && do_wr && adr_i == pio_pkg::PIN_IDX[0] && sel_i[1:0] == 2'b11
        |=> lat_all[15:0] == ($past(dat_i[15:0]) & pio_pkg::IMPL_MASK[0])
    ) else $error("pin register write missed latch");

    chk_latch_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && latch_rd && adr_i == pio_pkg::LAT_IDX[3]
        |=> ack_o && dat_o[15:0] == $past(lat_all[63:48])
    ) else $error("latch read wrong");

    chk_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ack_o |=> !ack_o
    ) else $error("ack held over two cycles");

    chk_adc_digital: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && do_wr && hit_an && sel_i[1:0] == 2'b11
        |=> adc_en_o == $past(dat_i[pio_pkg::AN_W-1:0])
    ) else $error("converter routing does not follow config");
endmodule
`default_nettype wire

/* rtl/pio_pkg.sv */
// Shared constants and carrier types for the parallel port bank
package pio_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int NPORT = 5; // Ports B, C, D, E, F in that order
    localparam int PW = 16; // Bits per port
    localparam int NPIN = NPORT * PW; // Flattened pin count
    localparam int IW = 12; // Register index width
    localparam int AN_W = 9; // Analog channels, on port B low bits

    typedef logic [NPIN-1:0] pin_vec_t;
    typedef logic [PW-1:0] port_word_t;

    // ---------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [IW-1:0] DIR_IDX [NPORT] =
        '{12'h2c6, 12'h2cc, 12'h2d2, 12'h2d8, 12'h2de};
    localparam logic [IW-1:0] PIN_IDX [NPORT] =
        '{12'h2c8, 12'h2ce, 12'h2d4, 12'h2da, 12'h2e0};
    localparam logic [IW-1:0] LAT_IDX [NPORT] =
        '{12'h2ca, 12'h2d0, 12'h2d6, 12'h2dc, 12'h2e2};
    localparam logic [IW-1:0] ANALOG_IDX = 12'h2e4;

    // ---------------------------------------------------------------
    // Implemented bits, reset values, pin sharing
    // ---------------------------------------------------------------
    localparam port_word_t IMPL_MASK [NPORT] =
        '{16'h01ff, 16'he000, 16'h000f, 16'h013f, 16'h007f};
    // Pins whose only other user is an input function
    localparam port_word_t DEDICATED [NPORT] =
        '{16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0000};
    localparam port_word_t LAT_RST = 16'h0000;
    localparam logic [AN_W-1:0] ANALOG_RST = 9'h000;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    // Peripheral side of every pad: ownership, data, enable (low=drive)
    typedef struct packed {
        pin_vec_t own;
        pin_vec_t data;
        pin_vec_t oe_n;
    } periph_t;

    // Pad cell drive: data and enable (low = driving)
    typedef struct packed {
        pin_vec_t data;
        pin_vec_t oe_n;
    } pad_drv_t;
endpackage

/* rtl/port_regs.sv */
// Direction and output latch storage for one port
`timescale 1ns/1ps
`default_nettype none
module port_regs #(
    parameter logic [15:0] MASK = 16'hffff
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wr_dir_i,
    input wire logic wr_lat_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] dir_o,
    output logic [15:0] lat_o
);
    // ---------------------------------------------------------------
    // Byte lane merge
    // ---------------------------------------------------------------
    wire logic [15:0] lane_mask; // Bytes the master writes
    wire logic [15:0] dir_next;
    wire logic [15:0] lat_next;

    assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    // Missing bits never store, so they always read as zero
    assign dir_next = ((dir_o & ~lane_mask) | (wdata_i & lane_mask)) & MASK;
    assign lat_next = ((lat_o & ~lane_mask) | (wdata_i & lane_mask)) & MASK;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // Reset makes every implemented pin an input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_o <= MASK;
            lat_o <= pio_pkg::LAT_RST;
        end else if (ce_i) begin
            if (wr_dir_i) begin
                dir_o <= dir_next;
            end
            if (wr_lat_i) begin
                lat_o <= lat_next;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/pad_partner.sv */
// Pads and shared peripherals as seen from outside the port bank
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
    input wire pio_pkg::pad_drv_t pad_i, // Drive from the bank
    input wire pio_pkg::pin_vec_t ext_i, // Outside level, changes often
    input wire pio_pkg::periph_t cmd_i, // Peripheral activity wanted
    output pio_pkg::periph_t periph_o,
    output pio_pkg::pin_vec_t pad_lvl_o
);
    // ---------------------------------------------------------------
    // Peripherals and wire level
    // ---------------------------------------------------------------
    // Peripherals act only as the bench commands
    assign periph_o = cmd_i;
    // Released pad shows the outside pattern, never the old drive
    assign pad_lvl_o = (pad_i.data & ~pad_i.oe_n) | (ext_i & pad_i.oe_n);
endmodule
`default_nettype wire

/* verif/parallel_io_port_bank_bench.sv */
// Self-checking bench for the parallel port bank
`timescale 1ns/1ps
`default_nettype none
module parallel_io_port_bank_bench;
    // ---------------------------------------------------------------
    // Signals and reference model
    // ---------------------------------------------------------------
    logic clk_i = 1'b0; // 10 MHz
    logic rst_i = 1'b1;
    logic ce = 1'b1; // Clock enable, dropped now and then while idle
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [13:2] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic [8:0] adc_en;
    pio_pkg::periph_t cmd = '0; // Peripheral activity
    pio_pkg::periph_t periph;
    pio_pkg::pin_vec_t ext = '0; // Outside level of free pads
    pio_pkg::pin_vec_t pad_lvl;
    pio_pkg::pin_vec_t periph_in;
    pio_pkg::pad_drv_t pad;
    pio_pkg::pin_vec_t impl;
    int error_cnt = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'h0000_0013; // Fixed seed
    logic [15:0] m_dir [5];
    logic [15:0] m_lat [5];
    logic [8:0] m_an;
    assign impl = {pio_pkg::IMPL_MASK[4], pio_pkg::IMPL_MASK[3],
        pio_pkg::IMPL_MASK[2], pio_pkg::IMPL_MASK[1], pio_pkg::IMPL_MASK[0]};

    parallel_io_port_bank uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .periph_i(periph), .pad_in_i(pad_lvl), .pad_o(pad),
        .periph_in_o(periph_in), .adc_en_o(adc_en));
    pad_partner far_side (.pad_i(pad), .ext_i(ext), .cmd_i(cmd),
        .periph_o(periph), .pad_lvl_o(pad_lvl));

    // Free-running clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic r80(output pio_pkg::pin_vec_t v);
        logic [47:0] hi;
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        hi[47:32] = rnd[15:0];
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        hi[31:0] = rnd;
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        v = {hi, rnd};
    endtask

    // Expected pad drive from the model
    function automatic pio_pkg::pad_drv_t exp_pad();
        pio_pkg::pad_drv_t e;
        int p;
        int b;
        for (int k = 0; k < pio_pkg::NPIN; k++) begin
            p = k / 16;
            b = k % 16;
            e.oe_n[k] = ~m_dir[p][b] ? 1'b0 : 1'b1;
            e.data[k] = m_lat[p][b];
            if (!pio_pkg::IMPL_MASK[p][b]) begin
                e.oe_n[k] = 1'b1;
            end else if (cmd.own[k] && !pio_pkg::DEDICATED[p][b]) begin
                e.oe_n[k] = cmd.oe_n[k];
                e.data[k] = cmd.data[k];
            end
        end
        return e;
    endfunction

    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input pio_pkg::pin_vec_t exp,
                           input pio_pkg::pin_vec_t got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pad side against the model, two idle cycles after any change
    task automatic chk_pads();
        pio_pkg::pad_drv_t e;
        repeat (2) @(posedge clk_i);
        e = exp_pad();
        chk_vec("pad enable", e.oe_n, pad.oe_n);
        chk_vec("pad data", e.data & ~e.oe_n, pad.data & ~pad.oe_n);
        chk_vec("periph input", pad_lvl & impl, periph_in);
        chk_word("converter", {23'h0, m_an}, {23'h0, adc_en});
    endtask

    // One register access; k: 0 dir, 1 pin, 2 latch, 3 analog, 4 hole
    task automatic acc(input logic we, input int p, input int k,
                       input logic [1:0] s, input logic [15:0] d,
                       input logic chg, input pio_pkg::pin_vec_t x);
        logic [15:0] lm;
        logic [15:0] pw;
        logic [31:0] e;
        pio_pkg::pad_drv_t ep;
        int n;
        ep = exp_pad();
        pw = ((ep.data & ~ep.oe_n) | (ext & ep.oe_n)) >> (p * 16);
        pw = pw & pio_pkg::IMPL_MASK[p];
        if (p == 0) pw[8:0] = pw[8:0] & ~m_an;
        lm = {{8{s[1]}}, {8{s[0]}}};
        e = k == 0 ? m_dir[p] : k == 1 ? pw : k == 2 ? m_lat[p] :
            k == 3 ? {23'h0, m_an} : 32'h0000_0000;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        sel_i <= {2'h0, s};
        dat_i <= {16'hffff, d};
        adr_i <= k == 0 ? pio_pkg::DIR_IDX[p] : k == 1 ? pio_pkg::PIN_IDX[p] :
            k == 2 ? pio_pkg::LAT_IDX[p] : k == 3 ? pio_pkg::ANALOG_IDX : 12'h2e6;
        if (chg) ext <= x;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk_word("ack", 32'h1, 32'h0);
        if (!we) chk_word("read", e, dat_o);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (we && k == 0) m_dir[p] = ((m_dir[p] & ~lm) | (d & lm)) & pio_pkg::IMPL_MASK[p];
        if (we && (k == 1 || k == 2)) m_lat[p] = ((m_lat[p] & ~lm) | (d & lm)) & pio_pkg::IMPL_MASK[p];
        if (we && k == 3) m_an = ((m_an & ~lm[8:0]) | (d[8:0] & lm[8:0]));
        chk_pads();
    endtask

    task automatic conclude();
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        pio_pkg::pin_vec_t v;
        for (int p = 0; p < 5; p++) begin
            m_dir[p] = pio_pkg::IMPL_MASK[p];
            m_lat[p] = 16'h0000;
        end
        m_an = 9'h000;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, hole and analog included
        for (int i = 0; i < 17; i++) acc(1'b0, i % 5, i / 5 + (i / 15) * (i % 5), 2'h3, 16'h0000, 1'b0, ext);
        // Pad change at the request edge is seen one read later
        acc(1'b0, 3, 1, 2'h3, 16'h0000, 1'b1, impl);
        acc(1'b0, 3, 1, 2'h3, 16'h0000, 1'b0, ext);
        repeat (300) begin
            r80(v);
            if (v[3:0] == 4'h0) begin
                @(posedge clk_i);
                cmd.own <= v & impl;
                r80(v);
                cmd.data <= v;
                r80(v);
                cmd.oe_n <= v;
                r80(v);
                ext <= v;
                chk_pads();
            end
            // Freeze one idle cycle; state must survive it unchanged
            if (v[15:13] == 3'h0) begin
                @(posedge clk_i);
                ce <= 1'b0;
                @(posedge clk_i);
                ce <= 1'b1;
            end
            acc(v[4], v[7:5] % 5, v[10:8] % 5, v[12:11], v[31:16], 1'b0, ext);
            if (v[4] && v[10:8] % 5 == 3) acc(1'b1, 0, 0, 2'h3, m_dir[0] | {7'h00, m_an}, 1'b0, ext);
        end
        conclude();
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
